//--- pkg/exit_info_defines.vh
`ifndef EXIT_INFO_DEFINES_VH
`define EXIT_INFO_DEFINES_VH
// ----------------------------------------
// Event-in-delivery record layout
// ----------------------------------------
`define EVT_VEC_LSB 0
`define EVT_VEC_MSB 7
`define EVT_CLASS_LSB 8
`define EVT_CLASS_MSB 10
`define EVT_ERRV_BIT 11
`define EVT_UNDEF_BIT 12
`define EVT_VALID_BIT 31
// ----------------------------------------
// Event classes
// ----------------------------------------
`define CLS_EXT_INT 3'h0
`define CLS_NMI 3'h2
`define CLS_HW_EXC 3'h3
`define CLS_SW_INT 3'h4
`define CLS_PRIV_SW_EXC 3'h5
`define CLS_SW_EXC 3'h6
// ----------------------------------------
// Operand descriptor layout
// ----------------------------------------
`define OPD_SCALE_LSB 0
`define OPD_FIRST_REGISTER_OPERAND_LSB 3
`define OPD_ASIZE_LSB 7
`define OPD_MEMREG_BIT 10
`define OPD_SEG_LSB 15
`define OPD_IDX_LSB 18
`define OPD_IDXINV_BIT 22
`define OPD_BASE_LSB 23
`define OPD_BASEINV_BIT 27
`define OPD_SECOND_REGISTER_OPERAND_LSB 28
// ----------------------------------------
// Exit instruction kinds
// ----------------------------------------
`define INS_OTHER 3'h0
`define INS_CLEAR 3'h1
`define INS_LOAD_PTR 3'h2
`define INS_STORE_PTR 3'h3
`define INS_FIELD_READ 3'h4
`define INS_FIELD_WRITE 3'h5
`define INS_ENABLE 3'h6
// ----------------------------------------
// Record select codes for field reads
// ----------------------------------------
`define SEL_EVT_INFO 4'h0
`define SEL_EVT_ERR 4'h1
`define SEL_LEN 4'h2
`define SEL_GLA 4'h3
`define SEL_OPD 4'h4
`define SEL_IO_CNT 4'h5
`define SEL_IO_SRC 4'h6
`define SEL_IO_DST 4'h7
`define SEL_IO_IP 4'h8
`endif

//--- rtl/vm_exit_info_capture.v
// Notes on behaviour
// - Info bits 7:0 vector, 10:8 class
// - Bit 11 set when error code carried
// - Bits 30:13 zero, bit 31 valid
// - Hardware exception error code copied separately
// - Exits during delivery record the event
// - Instruction length stored on instruction exits
// - Linear address on three exit kinds
// - Six control instructions fill operand descriptor
// - Descriptor bits 1:0 index scale
// - Descriptor bits 6:3 first register
// - Descriptor bits 9:7 address size
// - Bit 10 memory/register; bits 2,14:11 zero
// - Descriptor bits 17:15 segment code
// - Bits 21:18 index, bit 22 invalid
// - Bits 26:23 base, bit 27 invalid
// - Descriptor bits 31:28 second register
// - I/O context saved for post-I/O SYSTEM_MANAGEMENT_INTERRUPT
// - Records read-only; field writes fail
`timescale 1ns/100ps
`default_nettype none
`include "exit_info_defines.vh"
module vm_exit_info_capture #(
    parameter WIDE = 1
) (
    input wire mclk,
    input wire arst_n,
    // Exit sequencing strobe and cause
    input wire exit_valid,
    input wire exit_in_delivery,
    input wire [7:0] dlv_vector,
    input wire [2:0] dlv_class,
    input wire dlv_has_errcode,
    input wire [31:0] dlv_errcode,
    input wire exit_by_instr,
    input wire [31:0] instr_length,
    input wire [2:0] instr_kind,
    input wire exit_msw_load_mem,
    input wire exit_string_port,
    input wire exit_smi_after_io,
    input wire [63:0] linear_addr,
    // Operand details of the exiting instruction
    input wire opd_is_reg,
    input wire [1:0] opd_scale,
    input wire [3:0] opd_first_register_operand,
    input wire [1:0] opd_addr_size,
    input wire [2:0] opd_segment,
    input wire [3:0] opd_index,
    input wire opd_index_valid,
    input wire [3:0] opd_base,
    input wire opd_base_valid,
    input wire [3:0] opd_second_register_operand,
    // I/O context from before the last I/O instruction
    input wire [63:0] io_count,
    input wire [63:0] io_source,
    input wire [63:0] io_dest,
    input wire [63:0] io_ip,
    // Field-read and field-write port
    input wire field_rd,
    input wire field_wr,
    input wire [3:0] field_sel,
    output reg [63:0] field_rdata_ff,
    output reg field_wr_fail_ff
);

// ----------------------------------------
// Record storage
// ----------------------------------------
reg [31:0] evt_info_ff;
reg [31:0] evt_err_ff;
reg [31:0] len_ff;
reg [63:0] gla_ff;
reg [31:0] opd_ff;
reg [63:0] io_cnt_ff;
reg [63:0] io_src_ff;
reg [63:0] io_dst_ff;
reg [63:0] io_ip_ff;

wire sw_event;
wire hw_err;
wire ctl_instr;
wire short_form;
wire [63:0] addr_mask;
reg [31:0] nxt_info;
reg [31:0] nxt_opd;
reg [63:0] rd_mux;

// Narrow parts keep only the low word of address-sized records
assign addr_mask = (WIDE != 0) ? 64'hFFFFFFFFFFFFFFFF
                               : 64'h00000000FFFFFFFF;
assign sw_event = (dlv_class == `CLS_SW_INT) ||
                  (dlv_class == `CLS_PRIV_SW_EXC) ||
                  (dlv_class == `CLS_SW_EXC);
assign hw_err = exit_in_delivery && dlv_has_errcode &&
                (dlv_class == `CLS_HW_EXC);
assign ctl_instr = (instr_kind != `INS_OTHER) && (instr_kind <= `INS_ENABLE);
assign short_form = (instr_kind == `INS_CLEAR) ||
                    (instr_kind == `INS_LOAD_PTR) ||
                    (instr_kind == `INS_STORE_PTR) ||
                    (instr_kind == `INS_ENABLE);

// ----------------------------------------
// Record assembly
// ----------------------------------------
always @* begin
    nxt_info = 32'h00000000;
    if (exit_in_delivery) begin
        nxt_info[`EVT_VEC_MSB:`EVT_VEC_LSB] = dlv_vector;
        // Reserved class codes fold to hardware exception
        if (dlv_class == 3'h1 || dlv_class == 3'h7) begin
            nxt_info[`EVT_CLASS_MSB:`EVT_CLASS_LSB] = `CLS_HW_EXC;
        end else begin
            nxt_info[`EVT_CLASS_MSB:`EVT_CLASS_LSB] = dlv_class;
        end
        nxt_info[`EVT_ERRV_BIT] = dlv_has_errcode;
        nxt_info[`EVT_VALID_BIT] = 1'b1;
    end
end

always @* begin
    nxt_opd = 32'h00000000;
    nxt_opd[`OPD_SCALE_LSB+1:`OPD_SCALE_LSB] = opd_scale;
    nxt_opd[`OPD_FIRST_REGISTER_OPERAND_LSB+3:`OPD_FIRST_REGISTER_OPERAND_LSB] = opd_first_register_operand;
    // Unused size code 3 is never produced
    nxt_opd[`OPD_ASIZE_LSB+2:`OPD_ASIZE_LSB] =
        (opd_addr_size == 2'h3) ? 3'h2 : {1'b0, opd_addr_size};
    nxt_opd[`OPD_MEMREG_BIT] = opd_is_reg && !short_form;
    // Codes above 5 are unused segments
    nxt_opd[`OPD_SEG_LSB+2:`OPD_SEG_LSB] =
        (opd_segment > 3'h5) ? 3'h0 : opd_segment;
    nxt_opd[`OPD_IDX_LSB+3:`OPD_IDX_LSB] = opd_index;
    nxt_opd[`OPD_IDXINV_BIT] = !opd_index_valid;
    nxt_opd[`OPD_BASE_LSB+3:`OPD_BASE_LSB] = opd_base;
    nxt_opd[`OPD_BASEINV_BIT] = !opd_base_valid;
    nxt_opd[`OPD_SECOND_REGISTER_OPERAND_LSB+3:`OPD_SECOND_REGISTER_OPERAND_LSB] = opd_second_register_operand;
end

// ----------------------------------------
// Capture on exit
// ----------------------------------------
// Records not used by this exit keep their old contents; event info is always rewritten, and cleared when no event was in delivery.
always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        evt_info_ff <= 32'h00000000;
        evt_err_ff <= 32'h00000000;
        len_ff <= 32'h00000000;
        gla_ff <= 64'h0000000000000000;
        opd_ff <= 32'h00000000;
        io_cnt_ff <= 64'h0000000000000000;
        io_src_ff <= 64'h0000000000000000;
        io_dst_ff <= 64'h0000000000000000;
        io_ip_ff <= 64'h0000000000000000;
    end else if (exit_valid) begin
        evt_info_ff <= nxt_info;
        if (hw_err) begin
            evt_err_ff <= dlv_errcode;
        end
        if (exit_by_instr || (exit_in_delivery && sw_event)) begin
            len_ff <= instr_length;
        end
        if (exit_msw_load_mem || exit_string_port || exit_smi_after_io) begin
            gla_ff <= linear_addr & addr_mask;
        end
        if (exit_by_instr && ctl_instr) begin
            opd_ff <= nxt_opd;
        end
        if (exit_smi_after_io) begin
            io_cnt_ff <= io_count & addr_mask;
            io_src_ff <= io_source & addr_mask;
            io_dst_ff <= io_dest & addr_mask;
            io_ip_ff <= io_ip & addr_mask;
        end
    end
end

// ----------------------------------------
// Field read and write port
// ----------------------------------------
always @* begin
    case (field_sel)
        `SEL_EVT_INFO: rd_mux = {32'h00000000, evt_info_ff};
        `SEL_EVT_ERR: rd_mux = {32'h00000000, evt_err_ff};
        `SEL_LEN: rd_mux = {32'h00000000, len_ff};
        `SEL_GLA: rd_mux = gla_ff;
        `SEL_OPD: rd_mux = {32'h00000000, opd_ff};
        `SEL_IO_CNT: rd_mux = io_cnt_ff;
        `SEL_IO_SRC: rd_mux = io_src_ff;
        `SEL_IO_DST: rd_mux = io_dst_ff;
        `SEL_IO_IP: rd_mux = io_ip_ff;
        default: rd_mux = 64'h0000000000000000;
    endcase
end

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        field_rdata_ff <= 64'h0000000000000000;
        field_wr_fail_ff <= 1'b0;
    end else begin
        if (field_rd) begin
            field_rdata_ff <= rd_mux;
        end
        // Any write aimed at these records is refused, storage untouched
        field_wr_fail_ff <= field_wr && (field_sel <= `SEL_IO_IP);
    end
end

endmodule
`default_nettype wire

//--- dv/exit_info_props.sv
`timescale 1ns/100ps
`default_nettype none
module exit_info_props (
    input wire mclk,
    input wire arst_n,
    input wire field_rd,
    input wire field_wr,
    input wire [3:0] field_sel,
    input wire [63:0] field_rdata_ff,
    input wire field_wr_fail_ff
);
    // ----------------------------------------
    // Field port checks
    // ----------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    wire [63:0] q = field_rdata_ff;
    a_wr_refused: assert property (
        field_wr && field_sel <= 4'h8 |=> field_wr_fail_ff)
        else $error("write was not refused");
    a_fail_cause: assert property (
        field_wr_fail_ff |-> $past(field_wr) && $past(field_sel) <= 4'h8)
        else $error("refusal without a write");
    a_info_zero: assert property (
        field_rd && field_sel == 4'h0 |=> q[63:32] == 32'h0 && q[30:13] == 18'h0)
        else $error("info reserved bits set");
    a_info_class: assert property (
        field_rd && field_sel == 4'h0 |=> q[10:8] != 3'h1 && q[10:8] != 3'h7)
        else $error("unused event class");
    a_desc_zero: assert property (
        field_rd && field_sel == 4'h4 |=> q[2] == 1'b0 && q[14:11] == 4'h0)
        else $error("descriptor reserved bits set");
    a_desc_codes: assert property (
        field_rd && field_sel == 4'h4 |=> q[9:7] <= 3'h2 && q[17:15] <= 3'h5)
        else $error("unused descriptor code");
    a_short_upper: assert property (
        field_rd && (field_sel == 4'h1 || field_sel == 4'h2) |=> q[63:32] == 32'h0)
        else $error("32-bit record upper half set");
    a_unmapped_zero: assert property (
        field_rd && field_sel > 4'h8 |=> q == 64'h0)
        else $error("unmapped read not zero");
endmodule
bind vm_exit_info_capture exit_info_props u_props (.*);
`default_nettype wire

//--- dv/tb_vm_exit_info_capture.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb_vm_exit_info_capture;
    logic mclk = 1'b0, arst_n = 1'b0, exit_valid = 1'b0, exit_in_delivery = 1'b0;
    logic dlv_has_errcode = 1'b0, exit_by_instr = 1'b0, exit_msw_load_mem = 1'b0;
    logic exit_string_port = 1'b0, exit_smi_after_io = 1'b0, opd_is_reg = 1'b0;
    logic opd_index_valid = 1'b0, opd_base_valid = 1'b0;
    logic field_rd = 1'b0, field_wr = 1'b0, field_wr_fail_ff;
    logic [7:0] dlv_vector = 8'h0;
    logic [2:0] dlv_class = 3'h0, instr_kind = 3'h0, opd_segment = 3'h0;
    logic [31:0] dlv_errcode = 32'h0, instr_length = 32'h0;
    logic [63:0] linear_addr = 64'h0, io_count = 64'h0, io_source = 64'h0;
    logic [63:0] io_dest = 64'h0, io_ip = 64'h0, field_rdata_ff;
    logic [1:0] opd_scale = 2'h0, opd_addr_size = 2'h0;
    logic [3:0] opd_first_register_operand = 4'h0, opd_index = 4'h0, opd_base = 4'h0;
    logic [3:0] opd_second_register_operand = 4'h0, field_sel = 4'h0;
    logic [63:0] exp [0:15];
    logic [63:0] msk [0:15];
    int n_errors = 0, samples_checked = 0;
    vm_exit_info_capture uut (.*);
    always #5 mclk = ~mclk;
    // ----------------------------------------
    // Expectations
    // ----------------------------------------
    function automatic logic [31:0] dsc();
        logic [2:0] sg;
        sg = (opd_segment > 3'h5) ? 3'h0 : opd_segment;
        return {opd_second_register_operand, !opd_base_valid, opd_base, !opd_index_valid, opd_index,
            sg, 4'h0, opd_is_reg && instr_kind inside {3'h4, 3'h5},
            (opd_addr_size == 2'h3) ? 3'h2 : {1'b0, opd_addr_size},
            opd_first_register_operand, 1'b0, opd_scale};
    endfunction
    task automatic clr_exp();
        for (int i = 0; i < 16; i++) begin
            exp[i] = 64'h0;
            msk[i] = 64'hFFFF_FFFF_FFFF_FFFF;
        end
    endtask
    // Leaves exit_valid high so exits can run back to back
    task automatic do_exit();
        {dlv_vector, dlv_class, dlv_has_errcode, exit_by_instr, exit_in_delivery,
            exit_msw_load_mem, exit_string_port, exit_smi_after_io, opd_is_reg,
            opd_scale, opd_first_register_operand, opd_addr_size, opd_segment, opd_index,
            opd_index_valid, opd_base, opd_base_valid, opd_second_register_operand} = 43'({$urandom,
            $urandom});
        if (dlv_class == 3'h1 || dlv_class == 3'h7)
            dlv_has_errcode = 1'b0;
        instr_kind = 3'($urandom % 7);
        dlv_errcode = $urandom;
        instr_length = $urandom;
        linear_addr = {$urandom, $urandom};
        {io_count, io_source, io_dest, io_ip} = {$urandom, $urandom, $urandom,
            $urandom, $urandom, $urandom, $urandom, $urandom};
        exit_valid = 1'b1;
        exp[0] = {33'h1, 19'h0, dlv_has_errcode, (dlv_class == 3'h1 ||
            dlv_class == 3'h7) ? 3'h3 : dlv_class, dlv_vector};
        msk[0] = exit_in_delivery ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h8000_0000;
        if (!exit_in_delivery)
            exp[0] = 64'h0;
        if (exit_in_delivery && dlv_class == 3'h3 && dlv_has_errcode)
            exp[1] = {32'h0, dlv_errcode};
        if (exit_by_instr || exit_in_delivery && dlv_class inside {[3'h4:3'h6]})
            exp[2] = {32'h0, instr_length};
        if (exit_msw_load_mem || exit_string_port || exit_smi_after_io)
            exp[3] = linear_addr;
        if (exit_by_instr && instr_kind != 3'h0)
            exp[4] = {32'h0, dsc()};
        if (exit_smi_after_io)
            {exp[5], exp[6], exp[7], exp[8]} = {io_count, io_source, io_dest, io_ip};
        @(posedge mclk);
        #1;
    endtask
    task automatic chk_all();
        for (int i = 0; i < 16; i++) begin
            field_rd = 1'b1;
            field_sel = 4'(i);
            @(posedge mclk);
            #1;
            `CHK(field_rdata_ff & msk[i], exp[i])
        end
        field_rd = 1'b0;
    endtask
    task automatic summarize();
        $display("checks=%0d errors=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        summarize();
    end
    initial begin
        void'($urandom(84));
        clr_exp();
        repeat (6) @(posedge mclk);
        #1 arst_n = 1'b1;
        chk_all();
        $display("test reset_values done");
        repeat (30) begin
            repeat ($urandom % 3 + 1) do_exit();
            exit_valid = 1'b0;
            chk_all();
        end
        $display("test random_exits done");
        for (int s = 0; s < 16; s++) begin
            field_wr = 1'b1;
            field_sel = 4'(s);
            @(posedge mclk);
            #1;
            `CHK(field_wr_fail_ff, s <= 8)
        end
        field_wr = 1'b0;
        chk_all();
        $display("test write_refusal done");
        arst_n = 1'b0;
        @(posedge mclk);
        #1 arst_n = 1'b1;
        clr_exp();
        chk_all();
        $display("test mid_reset done");
        summarize();
    end
endmodule
`default_nettype wire
